// ### core/clkgate_params.svh
// Constants for the deep-sleep clock gating and software reset slice.
`ifndef CLKGATE_PARAMS_SVH
`define CLKGATE_PARAMS_SVH
// ----------------------------------------------------------------------
// Register byte offsets, decoded on haddr[11:2].
// ----------------------------------------------------------------------
`define SRST_OFFSET 12'h040
`define DCG_OFFSET 12'h128
`define STATUS_OFFSET 12'h200
// ----------------------------------------------------------------------
// Reset values and writable-bit masks.
// ----------------------------------------------------------------------
`define WORD_RESET 32'h00000000
`define UNIT_RESET 9'h000
`define DCG_MASK 32'h5000007f
`define SRST_MASK 32'h00100048
// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define DCG_PHY_BIT 30
`define DCG_MAC_BIT 28
`define DCG_PORT_MSB 6
`define DCG_PORT_LSB 0
`define SRST_PWM_BIT 20
`define SRST_HIBER_BIT 6
`define SRST_WDOG_BIT 3
// ----------------------------------------------------------------------
// Bus encodings.
// ----------------------------------------------------------------------
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'b0
`endif

// ### core/clkgate_pkg.sv
// Types shared by the clock gating slice.
package clkgate_pkg;
  // One bus word.
  typedef logic [31:0] word_t;
  // Unit enables: {phy, mac, port g .. port a}.
  typedef logic [8:0] unit_vec_t;
  // Power mode that selects the gating set.
  typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP} power_mode_t;
endpackage

// ### core/gate_sel_if.sv
// Signals between the register slice and the gating set selector.
`timescale 1ns/1ps
interface gate_sel_if;
  clkgate_pkg::word_t run_set;     // Run-mode gating word.
  clkgate_pkg::word_t sleep_set;   // Sleep-mode gating word.
  clkgate_pkg::word_t deep_set;    // Deep-sleep gating word.
  logic auto_en;                   // Automatic gating enable.
  logic sleep_mode;                // Processor is in sleep.
  logic deep_mode;                 // Processor is in deep sleep.
  clkgate_pkg::unit_vec_t active;  // Effective unit clock enables.
  modport sel (input run_set, sleep_set, deep_set, auto_en, sleep_mode, deep_mode,
               output active);
  modport ctl (output run_set, sleep_set, deep_set, auto_en, sleep_mode, deep_mode,
               input active);
endinterface

// ### core/gate_select.sv
// Selects the gating set for the current power mode and registers it.
`timescale 1ns/1ps
`include "clkgate_params.svh"
module gate_select (
  input wire logic hclk,     // System clock.
  input wire logic hresetn,  // Asynchronous reset, active low.
  gate_sel_if.sel gs         // Gating sets in, enables out.
);
  // ----------------------------------------------------------------------
  // Packing of a gating word into the unit vector.
  // ----------------------------------------------------------------------
  // Picks the phy, mac and port enable bits out of a gating word.
  function automatic clkgate_pkg::unit_vec_t pack_units(input clkgate_pkg::word_t w);
    pack_units = {w[`DCG_PHY_BIT], w[`DCG_MAC_BIT], w[`DCG_PORT_MSB:`DCG_PORT_LSB]};
  endfunction

  clkgate_pkg::power_mode_t mode_d;  // Mode whose set applies now.
  clkgate_pkg::unit_vec_t active_d;  // Next effective enables.
  clkgate_pkg::unit_vec_t active_q;  // Effective enables.

  // Without automatic gating the run set always applies; deep sleep wins over sleep.
  always_comb begin
    if (!gs.auto_en) begin
      mode_d = clkgate_pkg::MODE_RUN;
    end else if (gs.deep_mode) begin
      mode_d = clkgate_pkg::MODE_DEEP;
    end else if (gs.sleep_mode) begin
      mode_d = clkgate_pkg::MODE_SLEEP;
    end else begin
      mode_d = clkgate_pkg::MODE_RUN;
    end
  end

  // Chooses the enable word of the selected mode.
  always_comb begin
    unique case (mode_d)
      clkgate_pkg::MODE_RUN: active_d = pack_units(gs.run_set);
      clkgate_pkg::MODE_SLEEP: active_d = pack_units(gs.sleep_set);
      clkgate_pkg::MODE_DEEP: active_d = pack_units(gs.deep_set);
    endcase
  end

  // Registers the enables so the clock gates see a glitch-free level.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      active_q <= `UNIT_RESET;
    end else begin
      active_q <= active_d;
    end
  end

  assign gs.active = active_q;

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  run_when_manual_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !gs.auto_en |=> gs.active == pack_units($past(gs.run_set)))
    else $error("Run set not applied while automatic gating is off.");
  deep_applies_a: assert property (@(posedge hclk) disable iff (!hresetn)
    gs.auto_en && gs.deep_mode |=> gs.active == pack_units($past(gs.deep_set)))
    else $error("Deep-sleep set not applied in deep sleep.");
  sleep_applies_a: assert property (@(posedge hclk) disable iff (!hresetn)
    gs.auto_en && gs.sleep_mode && !gs.deep_mode
      |=> gs.active == pack_units($past(gs.sleep_set)))
    else $error("Sleep set not applied in sleep.");
endmodule

// ### core/deep_sleep_gating_and_soft_reset.sv
// Deep-sleep clock gating and software reset registers on an AHB-Lite slave.
`timescale 1ns/1ps
`include "clkgate_params.svh"
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module deep_sleep_gating_and_soft_reset (
  input wire logic hclk,                        // System clock, 250 MHz.
  input wire logic hresetn,                     // Asynchronous reset, active low.
  input wire logic hsel,                        // Slave select.
  input wire logic [31:0] haddr,                // Byte address.
  input wire logic [1:0] htrans,                // Transfer type.
  input wire logic hwrite,                      // Write when high.
  input wire logic [2:0] hsize,                 // Transfer size.
  input wire logic [31:0] hwdata,               // Write data.
  input wire logic hready,                      // Bus ready.
  output logic [31:0] hrdata,                   // Read data.
  output logic hreadyout,                       // Slave ready.
  output logic hresp,                           // Slave response.
  input wire logic [31:0] run_clock_gate_2,     // Run-mode gating word.
  input wire logic [31:0] sleep_clock_gate_2,   // Sleep-mode gating word.
  input wire logic auto_clock_gating_enable,    // Sleep sets allowed.
  input wire logic sleep_mode,                  // Processor in sleep.
  input wire logic deep_sleep_mode,             // Processor in deep sleep.
  input wire logic [31:0] device_capability_1,  // Present-module mask.
  input wire logic [8:0] unit_access,           // Access request per unit.
  output logic [8:0] unit_clock_enable,         // Clock enable per unit.
  output logic unit_bus_fault,                  // Access hit a gated unit.
  output logic pwm_module_reset,                // Holds the modulator in reset.
  output logic hibernation_block_reset,         // Holds hibernation in reset.
  output logic watchdog_block_reset             // Holds the watchdog in reset.
);
  // ----------------------------------------------------------------------
  // Helper functions.
  // ----------------------------------------------------------------------
  // True when a byte address selects the word at the given offset.
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off);
    reg_hit = (addr[11:2] == off[11:2]);
  endfunction

  // Replaces only the bits under the mask; the rest keep their old value.
  function automatic clkgate_pkg::word_t merge_word(input clkgate_pkg::word_t old_w,
                                                    input clkgate_pkg::word_t new_w,
                                                    input clkgate_pkg::word_t mask);
    merge_word = (old_w & ~mask) | (new_w & mask);
  endfunction

  // ----------------------------------------------------------------------
  // Bus address phase.
  // ----------------------------------------------------------------------
  logic accept;                   // A word transfer is taken this cycle.
  logic wr_pend_q;                // A write data phase is in progress.
  logic [11:0] wr_addr_q;         // Offset of the pending write.
  clkgate_pkg::word_t dcg_q;      // Deep-sleep gating register.
  clkgate_pkg::word_t dcg_d;      // Its next value.
  clkgate_pkg::word_t srst_q;     // Software reset register.
  clkgate_pkg::word_t srst_d;     // Its next value.
  clkgate_pkg::word_t rd_mux;     // Read value for the address phase.
  clkgate_pkg::word_t hrdata_q;   // Registered read data.
  gate_sel_if gsel ();            // Link to the gating selector.

  // Only whole-word nonsequential or sequential transfers are taken.
  assign accept = hsel && htrans[1] && hready && (hsize == `HSIZE_WORD);

  // Remembers a write until its data arrives in the next cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else begin
      wr_pend_q <= accept && hwrite;
      if (accept && hwrite) begin
        wr_addr_q <= haddr[11:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register writes.
  // ----------------------------------------------------------------------
  // Gating writes touch only the phy, mac and port bits; reserved bits stay zero.
  always_comb begin
    dcg_d = dcg_q;
    if (wr_pend_q && reg_hit(wr_addr_q, `DCG_OFFSET)) begin
      dcg_d = merge_word(dcg_q, hwdata, `DCG_MASK);
    end
  end

  // Reset writes pass only where the module is present in the capability word.
  always_comb begin
    srst_d = srst_q;
    if (wr_pend_q && reg_hit(wr_addr_q, `SRST_OFFSET)) begin
      srst_d = merge_word(srst_q, hwdata, `SRST_MASK & device_capability_1);
    end
  end

  // Holds the gating register; every unit starts unclocked.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dcg_q <= `WORD_RESET;
    end else begin
      dcg_q <= dcg_d;
    end
  end

  // Holds the software reset register; no module is held in reset at start.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      srst_q <= `WORD_RESET;
    end else begin
      srst_q <= srst_d;
    end
  end

  // ----------------------------------------------------------------------
  // Register reads.
  // ----------------------------------------------------------------------
  // Gating and reset reads use next values so a read right after a write sees the new data; status shows the registered enables.
  always_comb begin
    rd_mux = `WORD_RESET;
    if (reg_hit(haddr[11:0], `DCG_OFFSET)) begin
      rd_mux = dcg_d;
    end else if (reg_hit(haddr[11:0], `SRST_OFFSET)) begin
      rd_mux = srst_d;
    end else if (reg_hit(haddr[11:0], `STATUS_OFFSET)) begin
      rd_mux = {23'h000000, gsel.active};
    end
  end

  // Captures read data at the end of the address phase; idle cycles show zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= `WORD_RESET;
    end else if (accept && !hwrite) begin
      hrdata_q <= rd_mux;
    end else begin
      hrdata_q <= `WORD_RESET;
    end
  end

  // The slice never inserts wait states and always answers OKAY.
  assign hrdata = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp = `HRESP_OKAY;

  // ----------------------------------------------------------------------
  // Gating set selection.
  // ----------------------------------------------------------------------
  // Hands the three gating sets and the mode to the selector.
  assign gsel.run_set = run_clock_gate_2;
  assign gsel.sleep_set = sleep_clock_gate_2;
  assign gsel.deep_set = dcg_q;
  assign gsel.auto_en = auto_clock_gating_enable;
  assign gsel.sleep_mode = sleep_mode;
  assign gsel.deep_mode = deep_sleep_mode;

  // Registers the effective enables for the present power mode.
  gate_select u_gate_select (
    .hclk(hclk),
    .hresetn(hresetn),
    .gs(gsel.sel)
  );

  // Drives the unit clock gates; a low bit also disables the unit.
  assign unit_clock_enable = gsel.active;

  // An access to a unit whose clock is off is faulted instead of completing.
  assign unit_bus_fault = |(unit_access & ~gsel.active);

  // ----------------------------------------------------------------------
  // Module resets.
  // ----------------------------------------------------------------------
  // A set bit keeps its module in reset until software clears it.
  assign pwm_module_reset = srst_q[`SRST_PWM_BIT];
  assign hibernation_block_reset = srst_q[`SRST_HIBER_BIT];
  assign watchdog_block_reset = srst_q[`SRST_WDOG_BIT];

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Address phase of a word write to the gating register.
  sequence wr_dcg_s;
    accept && hwrite && reg_hit(haddr[11:0], `DCG_OFFSET);
  endsequence

  // Address phase of a word write to the reset register.
  sequence wr_srst_s;
    accept && hwrite && reg_hit(haddr[11:0], `SRST_OFFSET);
  endsequence

  // Address phase of a word read of the gating register.
  sequence rd_dcg_s;
    accept && !hwrite && reg_hit(haddr[11:0], `DCG_OFFSET);
  endsequence

  // Address phase of a word read of the reset register.
  sequence rd_srst_s;
    accept && !hwrite && reg_hit(haddr[11:0], `SRST_OFFSET);
  endsequence

  // Address phase of a word read of the status word.
  sequence rd_status_s;
    accept && !hwrite && reg_hit(haddr[11:0], `STATUS_OFFSET);
  endsequence

  // Data phase of a write that lands on neither register.
  sequence wr_other_s;
    wr_pend_q && !reg_hit(wr_addr_q, `DCG_OFFSET) && !reg_hit(wr_addr_q, `SRST_OFFSET);
  endsequence

  reset_zero_a: assert property (
    $rose(hresetn) |-> (dcg_q == `WORD_RESET) && (srst_q == `WORD_RESET)
      && (unit_clock_enable == `UNIT_RESET))
    else $error("Registers not zero after reset.");
  reserved_zero_a: assert property (
    ((dcg_q & ~`DCG_MASK) == `WORD_RESET) && ((srst_q & ~`SRST_MASK) == `WORD_RESET))
    else $error("Reserved bit became nonzero.");
  gate_write_a: assert property (
    wr_dcg_s ##1 1'b1 |=> dcg_q == ($past(hwdata) & `DCG_MASK))
    else $error("Gating write did not land.");
  gate_readback_a: assert property (
    rd_dcg_s |=> hrdata == dcg_q)
    else $error("Gating read returned the wrong value.");
  srst_masked_a: assert property (
    wr_srst_s ##1 1'b1
      |=> ((srst_q ^ $past(srst_q)) & ~$past(device_capability_1)) == `WORD_RESET)
    else $error("Reset bit of an absent module changed.");
  pwm_reset_a: assert property (
    wr_srst_s ##1 (hwdata[`SRST_PWM_BIT] && device_capability_1[`SRST_PWM_BIT])
      |=> pwm_module_reset)
    else $error("Modulator reset not asserted.");
  hiber_reset_a: assert property (
    wr_srst_s ##1 (!hwdata[`SRST_HIBER_BIT] && device_capability_1[`SRST_HIBER_BIT])
      |=> !hibernation_block_reset)
    else $error("Hibernation reset not released.");
  // A set watchdog reset holds for two cycles unless a new write is already landing.
  wdog_reset_a: assert property (
    wr_srst_s ##1 (hwdata[`SRST_WDOG_BIT] && device_capability_1[`SRST_WDOG_BIT])
      |=> (watchdog_block_reset && wr_pend_q) or (watchdog_block_reset [*2]))
    else $error("Watchdog reset not held.");
  fault_gated_a: assert property (
    (|unit_access) && (unit_clock_enable == `UNIT_RESET) |-> unit_bus_fault)
    else $error("Access to unclocked unit not faulted.");
  fault_cause_a: assert property (
    unit_bus_fault |-> |(unit_access & ~unit_clock_enable))
    else $error("Fault raised for a clocked unit.");
  bus_okay_a: assert property (
    accept |=> hreadyout && (hresp == `HRESP_OKAY))
    else $error("Slave stalled or returned an error.");

  // Read data, refused sizes and register stability.
  srst_readback_a: assert property (
    rd_srst_s |=> hrdata == srst_q)
    else $error("Reset register read returned the wrong value.");
  status_read_a: assert property (
    rd_status_s |=> hrdata == {23'h000000, $past(unit_clock_enable)})
    else $error("Status read did not show the unit enables.");
  idle_zero_a: assert property (
    !(accept && !hwrite) |=> hrdata == `WORD_RESET)
    else $error("Read data not zero outside a read data phase.");
  size_refused_a: assert property (
    hsel && htrans[1] && hready && (hsize != `HSIZE_WORD) |=> !wr_pend_q)
    else $error("Transfer of a non-word size was taken.");
  gate_hold_a: assert property (
    !wr_pend_q |=> $stable(dcg_q))
    else $error("Gating register changed without a write.");
  srst_hold_a: assert property (
    !wr_pend_q |=> $stable(srst_q))
    else $error("Reset register changed without a write.");
  other_write_a: assert property (
    wr_other_s |=> $stable(dcg_q) && $stable(srst_q))
    else $error("Write to an unmapped place changed a register.");

  // Each module reset follows a permitted write in both directions.
  pwm_release_a: assert property (
    wr_srst_s ##1 (!hwdata[`SRST_PWM_BIT] && device_capability_1[`SRST_PWM_BIT])
      |=> !pwm_module_reset)
    else $error("Modulator reset not released.");
  hiber_hold_a: assert property (
    wr_srst_s ##1 (hwdata[`SRST_HIBER_BIT] && device_capability_1[`SRST_HIBER_BIT])
      |=> hibernation_block_reset)
    else $error("Hibernation reset not asserted.");
  wdog_release_a: assert property (
    wr_srst_s ##1 (!hwdata[`SRST_WDOG_BIT] && device_capability_1[`SRST_WDOG_BIT])
      |=> !watchdog_block_reset)
    else $error("Watchdog reset not released.");
  fault_free_a: assert property (
    (unit_clock_enable == 9'h1ff) |-> !unit_bus_fault)
    else $error("Fault raised while every unit is clocked.");
endmodule

// ### testbench/tb_deep_sleep_gating_and_soft_reset.sv
// Self-checking bench for the deep-sleep gating and software reset slice.
`timescale 1ns/1ps
`include "clkgate_params.svh"
module tb_deep_sleep_gating_and_soft_reset;
  // ----------------------------------------------------------------------
  // Signals and bench state
  // ----------------------------------------------------------------------
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp; // Bus control.
  logic [31:0] haddr, hwdata, hrdata; // Bus address and data.
  logic [1:0] htrans; // Transfer type.
  logic [2:0] hsize; // Transfer size.
  clkgate_pkg::word_t run_set, sleep_set, dcap; // Side-band gating words.
  logic auto_en, slp, deep; // Power mode inputs.
  logic [8:0] ua, uce; // Unit access requests and clock enables.
  logic fault, pwm_rst, hiber_rst, wdog_rst; // Fault and module resets.
  int fails, check_count; // Mismatch and comparison counts.
  clkgate_pkg::word_t rng_state, dcg_model, srst_model, rd, v; // Models.
  clkgate_pkg::unit_vec_t exp_uce; // Expected unit enables.
  // The one slave's ready closes the bus loop.
  assign hready = hreadyout;
  deep_sleep_gating_and_soft_reset uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .run_clock_gate_2(run_set), .sleep_clock_gate_2(sleep_set),
    .auto_clock_gating_enable(auto_en), .sleep_mode(slp), .deep_sleep_mode(deep),
    .device_capability_1(dcap), .unit_access(ua), .unit_clock_enable(uce),
    .unit_bus_fault(fault), .pwm_module_reset(pwm_rst),
    .hibernation_block_reset(hiber_rst), .watchdog_block_reset(wdog_rst)
  );
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Clock of 4 ns period.
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Xorshift generator, repeatable from its fixed start value.
  function automatic clkgate_pkg::word_t rnd();
    rng_state = rng_state ^ (rng_state << 13);
    rng_state = rng_state ^ (rng_state >> 17);
    rng_state = rng_state ^ (rng_state << 5);
    return rng_state;
  endfunction
  // Works out which gating set drives the unit enables.
  function automatic clkgate_pkg::unit_vec_t pick(input logic a, input logic s,
      input logic d, input clkgate_pkg::word_t r, input clkgate_pkg::word_t sl,
      input clkgate_pkg::word_t dg);
    clkgate_pkg::word_t w;
    w = !a ? r : (d ? dg : (s ? sl : r));
    return {w[30], w[28], w[6:0]};
  endfunction
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fails = fails + 1;
    end
  endtask
  // One single AHB-Lite transfer; read data is taken at the data-phase edge.
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
      input logic [2:0] sz, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    hsize <= sz;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Checks both registers, the unit enables and the module resets right after a reset.
  task automatic check_reset();
    dcg_model = `WORD_RESET;
    srst_model = `WORD_RESET;
    bus(1'b0, 32'h040, 32'h0, `HSIZE_WORD, rd);
    chk(rd, `WORD_RESET);
    bus(1'b0, 32'h128, 32'h0, `HSIZE_WORD, rd);
    chk(rd, `WORD_RESET);
    chk({23'h0, uce}, 32'h0);
    chk({29'h0, pwm_rst, hiber_rst, wdog_rst}, 32'h0);
  endtask
  // Watchdog: the whole run needs well under 4000 cycles.
  initial begin
    #20000;
    fails = fails + 1;
    give_verdict();
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    fails = 0;
    check_count = 0;
    rng_state = 32'hed1a;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = `HSIZE_WORD;
    hwdata = 32'h0;
    run_set = 32'h0;
    sleep_set = 32'h0;
    dcap = 32'h0;
    auto_en = 1'b0;
    slp = 1'b0;
    deep = 1'b0;
    ua = 9'h000;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_reset();
    // Random traffic with all-ones and all-zeros corners in the first passes.
    for (int i = 0; i < 40; i++) begin
      v = (i == 0) ? 32'hffffffff : rnd();
      bus(1'b1, 32'h128, v, `HSIZE_WORD, rd);
      dcg_model = v & `DCG_MASK;
      bus(1'b0, 32'h128, 32'h0, `HSIZE_WORD, rd);
      chk(rd, dcg_model);
      // Mode inputs change; the selector registers them one cycle later.
      v = rnd();
      run_set <= rnd();
      sleep_set <= rnd();
      auto_en <= (i < 4) ? 1'b1 : v[0];
      deep <= (i < 4) ? (i[0] == 1'b0) : v[1];
      slp <= v[2];
      dcap <= (i == 0) ? 32'h0 : ((i == 1) ? 32'hffffffff : rnd());
      repeat (2) @(posedge hclk);
      exp_uce = pick(auto_en, slp, deep, run_set, sleep_set, dcg_model);
      chk({23'h0, uce}, {23'h0, exp_uce});
      // Access requests raise a fault when they hit a stopped unit.
      ua <= (i == 2) ? 9'h1ff : v[12:4];
      #1;
      chk({31'h0, fault}, {31'h0, |(ua & ~exp_uce)});
      // Software reset writes filtered by the capability mask.
      v = (i < 2) ? 32'hffffffff : rnd();
      bus(1'b1, 32'h040, v, `HSIZE_WORD, rd);
      srst_model = (srst_model & ~(dcap & `SRST_MASK)) | (v & dcap & `SRST_MASK);
      bus(1'b0, 32'h040, 32'h0, `HSIZE_WORD, rd);
      chk(rd, srst_model);
      chk({31'h0, pwm_rst}, {31'h0, srst_model[20]});
      chk({31'h0, hiber_rst}, {31'h0, srst_model[6]});
      chk({31'h0, wdog_rst}, {31'h0, srst_model[3]});
    end
    // Unmapped place: writes vanish and reads return zero.
    bus(1'b1, 32'h300, 32'hffffffff, `HSIZE_WORD, rd);
    bus(1'b0, 32'h300, 32'h0, `HSIZE_WORD, rd);
    chk(rd, 32'h0);
    // A byte-sized write is ignored by the gating register.
    bus(1'b1, 32'h128, ~dcg_model, 3'h0, rd);
    bus(1'b0, 32'h128, 32'h0, `HSIZE_WORD, rd);
    chk(rd, dcg_model);
    // Deep sleep with automatic gating picks up the written gating word.
    auto_en <= 1'b1;
    deep <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({23'h0, uce}, {23'h0, dcg_model[30], dcg_model[28], dcg_model[6:0]});
    bus(1'b0, 32'h200, 32'h0, `HSIZE_WORD, rd);
    chk(rd, {23'h0, dcg_model[30], dcg_model[28], dcg_model[6:0]});
    // A second reset in mid-run brings everything back to zero.
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check_reset();
    give_verdict();
  end
endmodule
